// ---- logic/sapc_pkg.sv ----
// Purpose: Constants for the serializer analog page register bank
// Assumes: AXI4-Lite, 32-bit data, one register per aligned word
// Notes:   Byte address of a register is four times its index
package sapc_pkg;
   localparam int          ADDR_W      = 8;
   localparam logic [15:0] PAGE_SERDES = 16'h6A00;
   localparam logic [15:0] PAGE_RESET  = 16'h0000;
   // Register indices
   localparam logic [5:0]  IDX_MULT    = 6'h16;
   localparam logic [5:0]  IDX_PLLPDN  = 6'h17;
   localparam logic [5:0]  IDX_OVRSEL  = 6'h1A;
   localparam logic [5:0]  IDX_SWING   = 6'h1B;
   localparam logic [5:0]  IDX_PAGE    = 6'h3F;
   // Field positions
   localparam int          POS_MULT    = 0;
   localparam int          POS_PLLRST  = 6;
   localparam int          POS_SLP_UP  = 5;
   localparam int          POS_SLP_LO  = 3;
   localparam int          POS_OVR_RT  = 1;
   localparam int          POS_SWING   = 5;
   localparam int          POS_OVR_EN  = 3;
   // Reset values
   localparam logic [1:0]  RST_MULT    = 2'h0;
   localparam logic [2:0]  RST_SWING   = 3'h0;
   localparam logic        RST_BIT     = 1'b0;
   // Multiplier codes and their meaning
   localparam logic [1:0]  MUL_CODE_20 = 2'h0;
   localparam logic [1:0]  MUL_CODE_40 = 2'h2;
   localparam logic [5:0]  MUL_X20     = 6'h14;
   localparam logic [5:0]  MUL_X40     = 6'h28;
   localparam logic [2:0]  LANES_X20   = 3'h4;
   localparam logic [2:0]  LANES_X40   = 3'h2;
   localparam logic [5:0]  MUL_NONE    = 6'h00;
   localparam logic [2:0]  LANES_NONE  = 3'h0;
   // Output swing in mVpp per code
   localparam logic [9:0]  SWING_MV [8] = '{
      10'd860, 10'd810, 10'd770, 10'd745,
      10'd960, 10'd930, 10'd905, 10'd880};
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [5:0] factor;
      logic [2:0] lanes;
   } sapc_mult_t;

   function automatic sapc_mult_t sapc_mult_decode(input logic [1:0] code);
      sapc_mult_t m;
      case (code)
         MUL_CODE_20: m = '{factor: MUL_X20, lanes: LANES_X20};
         MUL_CODE_40: m = '{factor: MUL_X40, lanes: LANES_X40};
         default:     m = '{factor: MUL_NONE, lanes: LANES_NONE};
      endcase
      return m;
   endfunction : sapc_mult_decode
endpackage : sapc_pkg

// ---- logic/sapc_pin_route.sv ----
// Purpose: Routes channel A fast over-range onto the sleep pin path
// Assumes: Pad level and flag are synchronous to clk
// Notes:   Result is registered, one cycle behind its inputs
`timescale 1ns/1ps
module sapc_pin_route (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // Controls
   input  wire logic route_a,
   input  wire logic override_en,
   // Sources
   input  wire logic sleep_pin_in,
   input  wire logic fast_overrange_flag_a,
   // Result
   output logic      sleep_pin_eff_q,
   output logic      override_active_q
);
   import sapc_pkg::*;
   logic sleep_pin_eff_d;
   logic override_active_d;

   always_comb begin
      // Route bit only counts with the enable also set
      override_active_d = route_a & override_en;
      sleep_pin_eff_d   = override_active_d ? fast_overrange_flag_a
                                            : sleep_pin_in;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sleep_pin_eff_q   <= RST_BIT;
         override_active_q <= RST_BIT;
      end else begin
         sleep_pin_eff_q   <= sleep_pin_eff_d;
         override_active_q <= override_active_d;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   chk_ovr_routed: assert property (
      (route_a && override_en) |=>
         sleep_pin_eff_q == $past(fast_overrange_flag_a))
      else $error("over-range flag not on sleep pin path");
   chk_pin_normal: assert property (
      !(route_a && override_en) |=>
         sleep_pin_eff_q == $past(sleep_pin_in) && !override_active_q)
      else $error("sleep pin path not normal");
endmodule : sapc_pin_route

// ---- logic/sapc_regs.sv ----
// Purpose: Serializer analog page registers behind an AXI4-Lite slave
// Assumes: One outstanding write and one outstanding read at a time
// Notes:   Page register must hold the serializer page value for access
//
// Overview of operation
// - Multiplier code 00 x20/4 lanes, 10 x40/2
// - Lanes sleep only when both bits set
// - Sleeping lanes have output buffers disabled
// - Route plus enable puts flag on pin
// - Enable clear keeps sleep pin normal
// - Three-bit code selects one of eight swings
// - Registers decode at 16,17,1A,1B in page
`timescale 1ns/1ps
module sapc_regs (
   // Clock and reset
   input  wire logic                        clk,
   input  wire logic                        rst_n,
   // AXI4-Lite write address
   input  wire logic [sapc_pkg::ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                        s_axi_awvalid,
   output logic                             s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [31:0]                 s_axi_wdata,
   input  wire logic [3:0]                  s_axi_wstrb,
   input  wire logic                        s_axi_wvalid,
   output logic                             s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]                       s_axi_bresp,
   output logic                             s_axi_bvalid,
   input  wire logic                        s_axi_bready,
   // AXI4-Lite read
   input  wire logic [sapc_pkg::ADDR_W-1:0] s_axi_araddr,
   input  wire logic                        s_axi_arvalid,
   output logic                             s_axi_arready,
   output logic [31:0]                      s_axi_rdata,
   output logic [1:0]                       s_axi_rresp,
   output logic                             s_axi_rvalid,
   input  wire logic                        s_axi_rready,
   // Serializer PLL
   output logic [1:0]                       serializer_multiplier_select_q,
   output logic [5:0]                       pll_factor_q,
   output logic [2:0]                       lanes_per_adc_q,
   output logic                             pll_restart_q,
   // Lane output enables, order b3 a3 b0 a0
   output logic [3:0]                       lane_oe_q,
   // Transmitter amplitude
   output logic [2:0]                       output_amplitude_select_q,
   output logic [9:0]                       swing_mv_q,
   // Sleep pin path
   input  wire logic                        sleep_pin_in,
   input  wire logic                        fast_overrange_flag_a,
   output logic                             sleep_pin_eff_q,
   output logic                             override_active_q
);
   import sapc_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Bus state
   logic              aw_have_q, aw_have_d, w_have_q, w_have_d;
   logic [5:0]        waddr_q, waddr_d;
   logic [31:0]       wdata_q, wdata_d;
   logic [3:0]        wstrb_q, wstrb_d;
   logic              awready_d, wready_d, bvalid_d, arready_d, rvalid_d;
   logic [1:0]        bresp_d, rresp_d;
   logic [31:0]       rdata_d;
   logic              wr_fire, rd_fire;
   logic [5:0]        raddr;
   // Register state
   logic [15:0]       page_q, page_d;
   logic [1:0]        mult_d;
   logic              pllrst_d, slp_up_q, slp_up_d, slp_lo_q, slp_lo_d;
   logic              ovr_rt_q, ovr_rt_d, ovr_en_q, ovr_en_d;
   logic [2:0]        swing_d;
   sapc_mult_t        mdec;

   function automatic logic mapped(input logic [5:0] idx,
                                   input logic [15:0] page);
      logic in_page;
      in_page = (page == PAGE_SERDES);
      case (idx)
         IDX_PAGE:                       mapped = 1'b1;
         IDX_MULT, IDX_PLLPDN,
         IDX_OVRSEL, IDX_SWING:          mapped = in_page;
         default:                        mapped = 1'b0;
      endcase
   endfunction : mapped

   assign wr_fire = aw_have_q & w_have_q & ~s_axi_bvalid;
   assign rd_fire = s_axi_arvalid & s_axi_arready;
   assign raddr   = s_axi_araddr[ADDR_W-1:2];

   ////////////////////////////////////////////////////////////////////////
   // Bus next state: address and data may arrive in either order
   always_comb begin
      aw_have_d = aw_have_q;
      w_have_d  = w_have_q;
      waddr_d   = waddr_q;
      wdata_d   = wdata_q;
      wstrb_d   = wstrb_q;
      bvalid_d  = s_axi_bvalid & ~s_axi_bready;
      bresp_d   = s_axi_bresp;
      if (s_axi_awvalid && s_axi_awready) begin
         aw_have_d = 1'b1;
         waddr_d   = s_axi_awaddr[ADDR_W-1:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_have_d = 1'b1;
         wdata_d  = s_axi_wdata;
         wstrb_d  = s_axi_wstrb;
      end
      if (wr_fire) begin
         aw_have_d = 1'b0;
         w_have_d  = 1'b0;
         bvalid_d  = 1'b1;
         bresp_d   = mapped(waddr_q, page_q) ? RESP_OKAY : RESP_SLVERR;
      end
      // Stall the next address until the response has been taken
      awready_d = ~aw_have_d & ~bvalid_d;
      wready_d  = ~w_have_d & ~bvalid_d;
      rvalid_d  = s_axi_rvalid & ~s_axi_rready;
      rdata_d   = s_axi_rdata;
      rresp_d   = s_axi_rresp;
      if (rd_fire) begin
         rvalid_d = 1'b1;
         rresp_d  = mapped(raddr, page_q) ? RESP_OKAY : RESP_SLVERR;
         rdata_d  = 32'h0000_0000;
         // Reserved bits and unmapped words read as zero
         if (mapped(raddr, page_q)) begin
            case (raddr)
               IDX_PAGE:   rdata_d[15:0] = page_q;
               IDX_MULT:   rdata_d[POS_MULT +: 2] =
                              serializer_multiplier_select_q;
               IDX_PLLPDN: begin
                  rdata_d[POS_PLLRST] = pll_restart_q;
                  rdata_d[POS_SLP_UP] = slp_up_q;
                  rdata_d[POS_SLP_LO] = slp_lo_q;
               end
               IDX_OVRSEL: rdata_d[POS_OVR_RT] = ovr_rt_q;
               IDX_SWING: begin
                  rdata_d[POS_SWING +: 3] = output_amplitude_select_q;
                  rdata_d[POS_OVR_EN]     = ovr_en_q;
               end
               default:    rdata_d = 32'h0000_0000;
            endcase
         end
      end
      arready_d = ~rvalid_d;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         aw_have_q     <= 1'b0;
         w_have_q      <= 1'b0;
         waddr_q       <= 6'h00;
         wdata_q       <= 32'h0000_0000;
         wstrb_q       <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rresp   <= RESP_OKAY;
         s_axi_rdata   <= 32'h0000_0000;
      end else begin
         aw_have_q     <= aw_have_d;
         w_have_q      <= w_have_d;
         waddr_q       <= waddr_d;
         wdata_q       <= wdata_d;
         wstrb_q       <= wstrb_d;
         s_axi_awready <= awready_d;
         s_axi_wready  <= wready_d;
         s_axi_bvalid  <= bvalid_d;
         s_axi_bresp   <= bresp_d;
         s_axi_arready <= arready_d;
         s_axi_rvalid  <= rvalid_d;
         s_axi_rresp   <= rresp_d;
         s_axi_rdata   <= rdata_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers: only documented fields are stored
   always_comb begin
      page_d   = page_q;
      mult_d   = serializer_multiplier_select_q;
      pllrst_d = pll_restart_q;
      slp_up_d = slp_up_q;
      slp_lo_d = slp_lo_q;
      ovr_rt_d = ovr_rt_q;
      ovr_en_d = ovr_en_q;
      swing_d  = output_amplitude_select_q;
      if (wr_fire && mapped(waddr_q, page_q)) begin
         if (waddr_q == IDX_PAGE) begin
            if (wstrb_q[0]) page_d[7:0]  = wdata_q[7:0];
            if (wstrb_q[1]) page_d[15:8] = wdata_q[15:8];
         end else if (wstrb_q[0]) begin
            case (waddr_q)
               IDX_MULT:   mult_d = wdata_q[POS_MULT +: 2];
               IDX_PLLPDN: begin
                  pllrst_d = wdata_q[POS_PLLRST];
                  slp_up_d = wdata_q[POS_SLP_UP];
                  slp_lo_d = wdata_q[POS_SLP_LO];
               end
               IDX_OVRSEL: ovr_rt_d = wdata_q[POS_OVR_RT];
               IDX_SWING: begin
                  swing_d  = wdata_q[POS_SWING +: 3];
                  ovr_en_d = wdata_q[POS_OVR_EN];
               end
               default:    mult_d = serializer_multiplier_select_q;
            endcase
         end
      end
      mdec = sapc_mult_decode(serializer_multiplier_select_q);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         page_q                         <= PAGE_RESET;
         serializer_multiplier_select_q <= RST_MULT;
         pll_restart_q                  <= RST_BIT;
         slp_up_q                       <= RST_BIT;
         slp_lo_q                       <= RST_BIT;
         ovr_rt_q                       <= RST_BIT;
         ovr_en_q                       <= RST_BIT;
         output_amplitude_select_q      <= RST_SWING;
         pll_factor_q                   <= MUL_X20;
         lanes_per_adc_q                <= LANES_X20;
         lane_oe_q                      <= 4'hF;
         swing_mv_q                     <= SWING_MV[0];
      end else begin
         page_q                         <= page_d;
         serializer_multiplier_select_q <= mult_d;
         pll_restart_q                  <= pllrst_d;
         slp_up_q                       <= slp_up_d;
         slp_lo_q                       <= slp_lo_d;
         ovr_rt_q                       <= ovr_rt_d;
         ovr_en_q                       <= ovr_en_d;
         output_amplitude_select_q      <= swing_d;
         pll_factor_q                   <= mdec.factor;
         lanes_per_adc_q                <= mdec.lanes;
         // One bit alone must not sleep the lanes
         lane_oe_q <= {4{~(slp_up_q & slp_lo_q)}};
         swing_mv_q <= SWING_MV[output_amplitude_select_q];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Sleep pin path
   sapc_pin_route u_pin_route (
      .clk                   (clk),
      .rst_n                 (rst_n),
      .route_a               (ovr_rt_q),
      .override_en           (ovr_en_q),
      .sleep_pin_in          (sleep_pin_in),
      .fast_overrange_flag_a (fast_overrange_flag_a),
      .sleep_pin_eff_q       (sleep_pin_eff_q),
      .override_active_q     (override_active_q)
   );

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   chk_lane_both_sleep: assert property (
      (slp_up_q && slp_lo_q) |=> lane_oe_q == 4'h0)
      else $error("lanes not disabled with both sleep bits");
   chk_lane_one_bit: assert property (
      !(slp_up_q && slp_lo_q) |=> lane_oe_q == 4'hF)
      else $error("lanes disabled by a single sleep bit");
   chk_mult_x20: assert property (
      serializer_multiplier_select_q == MUL_CODE_20 |=>
         pll_factor_q == MUL_X20 && lanes_per_adc_q == LANES_X20)
      else $error("code 00 not x20 four lanes");
   chk_mult_x40: assert property (
      serializer_multiplier_select_q == MUL_CODE_40 |=>
         pll_factor_q == MUL_X40 && lanes_per_adc_q == LANES_X40)
      else $error("code 10 not x40 two lanes");
   chk_swing_table: assert property (
      ##1 swing_mv_q == SWING_MV[$past(output_amplitude_select_q)])
      else $error("swing level does not follow code");
   chk_mult_write: assert property (
      (wr_fire && waddr_q == IDX_MULT && page_q == PAGE_SERDES
       && wstrb_q[0]) |=>
         serializer_multiplier_select_q == $past(wdata_q[1:0])
         && s_axi_bvalid && s_axi_bresp == RESP_OKAY)
      else $error("multiplier write not applied");
   chk_page_guard: assert property (
      (wr_fire && waddr_q == IDX_SWING && page_q != PAGE_SERDES) |=>
         $stable(output_amplitude_select_q) && s_axi_bresp == RESP_SLVERR)
      else $error("write outside page not refused");
   chk_rvalid_hold: assert property (
      (s_axi_rvalid && !s_axi_rready) |=>
         s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped before taken");
   chk_reset_fields: assert property (
      $rose(rst_n) |-> !pll_restart_q && !slp_up_q && !ovr_en_q)
      else $error("fields not zero after reset");

   cov_both_sleep: cover property (slp_up_q && slp_lo_q ##1 lane_oe_q == 4'h0);
   cov_override:   cover property (override_active_q);
   cov_x40:        cover property (lanes_per_adc_q == LANES_X40);
   cov_pll_pulse:  cover property (pll_restart_q ##[1:50] !pll_restart_q);
endmodule : sapc_regs

// ---- test/sapc_host_model.sv ----
// Purpose: Host that programs the serializer page over AXI4-Lite
// Assumes: One write and one read under way at a time
// Notes:   lag holds back bready/rready to act as a slow host
`timescale 1ns/1ps
module sapc_host_model (
   // Clock
   input  wire logic        clk,
   // Write channels
   output logic      [7:0]  awaddr,
   output logic             awvalid,
   input  wire logic        awready,
   output logic      [31:0] wdata,
   output logic      [3:0]  wstrb,
   output logic             wvalid,
   input  wire logic        wready,
   input  wire logic [1:0]  bresp,
   input  wire logic        bvalid,
   output logic             bready,
   // Read channels
   output logic      [7:0]  araddr,
   output logic             arvalid,
   input  wire logic        arready,
   input  wire logic [31:0] rdata,
   input  wire logic [1:0]  rresp,
   input  wire logic        rvalid,
   output logic             rready
);
   int lag = 0;
   initial begin
      {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
      {araddr, arvalid, rready} = '0;
   end
   ////////////////////////////////////////
   // Callers leave reserved bits zero
   // Released payload is inverted so a late sample shows up
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [1:0] r);
      logic aw_ok;
      logic w_ok;
      aw_ok = 1'h0;
      w_ok = 1'h0;
      @(posedge clk);
      awaddr  <= a;
      awvalid <= 1'h1;
      wdata   <= d;
      wstrb   <= s;
      wvalid  <= 1'h1;
      while (!(aw_ok && w_ok)) begin
         @(posedge clk);
         if (awvalid && awready) begin
            aw_ok = 1'h1;
            awvalid <= 1'h0;
            awaddr  <= ~a;
         end
         if (wvalid && wready) begin
            w_ok = 1'h1;
            wvalid <= 1'h0;
            wdata  <= ~d;
         end
      end
      repeat (lag) @(posedge clk);
      bready <= 1'h1;
      do @(posedge clk); while (!bvalid);
      r = bresp;
      bready <= 1'h0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
      @(posedge clk);
      araddr  <= a;
      arvalid <= 1'h1;
      do @(posedge clk); while (!arready);
      arvalid <= 1'h0;
      araddr  <= ~a;
      repeat (lag) @(posedge clk);
      rready <= 1'h1;
      do @(posedge clk); while (!rvalid);
      d = rdata;
      r = rresp;
      rready <= 1'h0;
   endtask : rd
endmodule : sapc_host_model

// ---- test/testbench.sv ----
// Purpose: Self-checking bench for the serializer page registers
// Assumes: Host model speaks AXI4-Lite; derived outputs lag 1 edge
// Notes:   Ends through final_report only
`timescale 1ns/1ps
module testbench;
   import sapc_pkg::*;
   logic              clk = 1'h0;
   logic              rst_n = 1'h0;
   logic              slp_in = 1'h0;
   logic              flag_a = 1'h0;
   wire logic [7:0]   awaddr, araddr;
   wire logic [31:0]  wdata, rdata;
   wire logic [3:0]   wstrb, oe;
   wire logic [1:0]   bresp, rresp, mult;
   wire logic         awvalid, awready, wvalid, wready, bvalid, bready;
   wire logic         arvalid, arready, rvalid, rready, restart;
   wire logic         eff, act;
   wire logic [5:0]   factor;
   wire logic [2:0]   lanes, amp;
   wire logic [9:0]   mv;
   int                miscompares = 0;
   int                num_checks = 0;
   int                cycles = 0;
   logic [31:0]       val;
   logic [1:0]        r2;
   int                mvt [8] = '{860, 810, 770, 745, 960, 930, 905, 880};
   always #20 clk = ~clk;
   sapc_host_model host (.clk(clk), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
   sapc_regs dut (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .serializer_multiplier_select_q(mult),
      .pll_factor_q(factor), .lanes_per_adc_q(lanes),
      .pll_restart_q(restart), .lane_oe_q(oe),
      .output_amplitude_select_q(amp), .swing_mv_q(mv),
      .sleep_pin_in(slp_in), .fast_overrange_flag_a(flag_a),
      .sleep_pin_eff_q(eff), .override_active_q(act));
   ////////////////////////////////////////
   task automatic final_report;
      $display("checks=%0d miscompares=%0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : final_report
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic w(input logic [5:0] i, input logic [31:0] d,
                    input logic [1:0] er);
      logic [1:0] r;
      host.wr({i, 2'h0}, d, 4'hF, r);
      chk(r, er);
   endtask : w
   task automatic rd(input logic [5:0] i, input logic [31:0] ed,
                     input logic [1:0] er);
      logic [31:0] d;
      logic [1:0]  r;
      host.rd({i, 2'h0}, d, r);
      chk(d, ed);
      chk(r, er);
   endtask : rd
   // Derived outputs trail the stored field by one edge
   task automatic settle;
      repeat (2) @(posedge clk);
      #1;
   endtask : settle
   // Hang guard: whole run needs well under a thousand cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         miscompares++;
         final_report();
      end
   end
   ////////////////////////////////////////
   initial begin
      repeat (3) @(posedge clk);
      #1;
      chk(factor, 20);
      chk(lanes, 4);
      chk(oe, 4'hF);
      chk(mv, 860);
      chk(eff, 0);
      repeat (2) @(posedge clk);
      rst_n <= 1'h1;
      rd(IDX_MULT, 0, RESP_SLVERR);
      w(IDX_MULT, 2, RESP_SLVERR);
      w(IDX_SWING, 32'hE8, RESP_SLVERR);
      w(6'h10, 1, RESP_SLVERR);
      w(IDX_PAGE, 32'h6A00, RESP_OKAY);
      rd(IDX_PAGE, 32'h6A00, RESP_OKAY);
      rd(6'h10, 0, RESP_SLVERR);
      rd(IDX_MULT, 0, RESP_OKAY);
      rd(IDX_PLLPDN, 0, RESP_OKAY);
      rd(IDX_OVRSEL, 0, RESP_OKAY);
      rd(IDX_SWING, 0, RESP_OKAY);
      for (int c = 0; c < 4; c++) begin
         w(IDX_MULT, c, RESP_OKAY);
         rd(IDX_MULT, c, RESP_OKAY);
         settle();
         chk(mult, c);
         chk(factor, c == 0 ? 20 : c == 2 ? 40 : 0);
         chk(lanes, c == 0 ? 4 : c == 2 ? 2 : 0);
      end
      w(IDX_MULT, 0, RESP_OKAY);
      // Low byte strobe off: register must keep its value
      host.wr({IDX_MULT, 2'h0}, 32'h2, 4'hE, r2);
      chk(r2, RESP_OKAY);
      rd(IDX_MULT, 0, RESP_OKAY);
      for (int v = 0; v < 3; v++) begin
         w(IDX_PLLPDN, {25'h0, v == 1, 6'h0}, RESP_OKAY);
         settle();
         chk(restart, v == 1);
      end
      for (int c = 0; c < 4; c++) begin
         val = {26'h0, c[1], 1'h0, c[0], 3'h0};
         w(IDX_PLLPDN, val, RESP_OKAY);
         rd(IDX_PLLPDN, val, RESP_OKAY);
         settle();
         chk(oe, c == 3 ? 4'h0 : 4'hF);
      end
      host.lag = 3;
      for (int c = 0; c < 8; c++) begin
         w(IDX_SWING, {24'h0, c[2:0], 5'h0}, RESP_OKAY);
         rd(IDX_SWING, {24'h0, c[2:0], 5'h0}, RESP_OKAY);
         settle();
         chk(amp, c);
         chk(mv, mvt[c]);
      end
      host.lag = 0;
      for (int k = 0; k < 4; k++) begin
         w(IDX_OVRSEL, {30'h0, k[0], 1'h0}, RESP_OKAY);
         w(IDX_SWING, {28'h0, k[1], 3'h0}, RESP_OKAY);
         for (int p = 0; p < 4; p++) begin
            @(posedge clk);
            slp_in <= p[0];
            flag_a <= p[1];
            settle();
            chk(eff, k == 3 ? p[1] : p[0]);
         end
         chk(act, k == 3);
      end
      // Second reset with fields set; pins quiet so no stale sample
      @(posedge clk);
      slp_in <= 1'h0;
      flag_a <= 1'h0;
      rst_n  <= 1'h0;
      repeat (5) @(posedge clk);
      rst_n <= 1'h1;
      settle();
      chk(act, 0);
      chk(oe, 4'hF);
      chk(restart, 0);
      rd(IDX_PAGE, 0, RESP_OKAY);
      rd(IDX_SWING, 0, RESP_SLVERR);
      final_report();
   end
endmodule : testbench
